/* File: rtl/rsc_pkg.sv */
// Operation
// - Procedure field: two control, two status bits
// - Master starts procedure by writing 3
// - Accepted procedure reads back 7
// - Good completion reads back 3
// - Failure sets error bit 3
// - Status word carries change bit 5
// - Master writes 0 to cancel procedure
// - Master polls without assuming any duration; tb reads the procedure word at fixed points, after a fixed number of updates
// - No procedures in startup parameter writes
// - Phases advance strictly 0 through 4
// - Phase roles: ring, address, cyclic, service, run
// - Optional pause after phase 2 completes
// - Cyclic data only after phase 4, fixed
// - Cyclic words set telegram length
// - Only operation data travels cyclically
// - One service word always in each telegram
// - One service word per update each way
// - Master initiates, drive only answers
// - One service request on ring at once
// - Sixteen-deep application queue, arrival order
// - Application queue before diagnostic requests
// - Service channel only after phase 2 done
// - Sync first, drive telegram, then data telegram
package rsc_pkg;
   // ==========================================================
   // Timing
   localparam int         CLK_NS     = 25;
   localparam int         UPDATE_US  = 100;
   localparam int         UPDATE_CYC = (UPDATE_US * 1000) / CLK_NS;
   localparam logic [11:0] TMR_LAST  = 12'(UPDATE_CYC - 1);
   localparam int         PROC_US    = 400;
   localparam int         PROC_UPD   = PROC_US / UPDATE_US;
   localparam logic [3:0] PTMR_INIT  = 4'(PROC_UPD);
   localparam logic [3:0] PTMR_ONE   = 4'h1;

   // ==========================================================
   // Sizes
   localparam int         QDEPTH     = 16;
   localparam int         QAW        = 4;
   localparam logic [4:0] QFULL      = 5'h10;
   localparam int         NCYC       = 4;
   localparam int         NPAR       = 8;
   localparam logic [2:0] CYC_MAX    = 3'h4;

   // ==========================================================
   // Phases; ncomp counts completed phases
   localparam logic [2:0] PH_CYC     = 3'h2;
   localparam logic [2:0] PH_LAST    = 3'h4;
   localparam logic [2:0] DONE_SVC   = 3'h3;
   localparam logic [2:0] DONE_ALL   = 3'h5;

   // ==========================================================
   // Procedure and status words
   localparam int          PB_SET     = 0;
   localparam int          PB_EN      = 1;
   localparam int          PB_EXEC    = 2;
   localparam int          PB_ERR     = 3;
   localparam int          SB_CHG     = 5;
   localparam logic [15:0] PROC_IDLE  = 16'h0000;
   localparam logic [15:0] PROC_START = 16'h0003;
   localparam logic [15:0] PROC_RUN   = 16'h0007;
   localparam logic [15:0] PROC_OK    = 16'h0003;
   localparam logic [15:0] PROC_FAIL  = 16'h000b;
   localparam logic [11:0] PROC_IDN   = 12'h106;
   localparam logic [15:0] PAR_RST    = 16'h0000;

   // ==========================================================
   // Service word control
   localparam logic [1:0] SC_NONE    = 2'h0;
   localparam logic [1:0] SC_HDR     = 2'h1;
   localparam logic [1:0] SC_DATA    = 2'h2;

   typedef enum logic [2:0] {
      EL_OPDATA = 3'h1,
      EL_NAME   = 3'h2,
      EL_ATTR   = 3'h3,
      EL_UNITS  = 3'h4,
      EL_MIN    = 3'h5,
      EL_MAX    = 3'h6
   } rsc_element_selector_t;

   typedef struct packed {
      logic        wr;
      rsc_element_selector_t   element_selector;
      logic [11:0] idn;
      logic [15:0] data;
   } rsc_req_t;

   typedef logic [NCYC-1:0][15:0] rsc_cyc_t;

   typedef enum logic [3:0] {
      U_IDLE = 4'b0001,
      U_MST  = 4'b0010,
      U_WAIT = 4'b0100,
      U_MDT  = 4'b1000
   } rsc_upd_t;

   typedef enum logic [1:0] {
      SV_IDLE = 2'b01,
      SV_HDR  = 2'b10
   } rsc_svc_t;
endpackage

/* File: rtl/rsc_link_if.sv */
`timescale 1ns/1ps
interface rsc_link_if;
   import rsc_pkg::*;
   logic           mst;
   logic [2:0]     phase;
   logic           at_valid;
   logic           at_ack;
   logic [15:0]    at_stat;
   logic [15:0]    at_svc;
   rsc_cyc_t       at_cyc;
   logic [2:0]     at_len;
   logic           mdt_valid;
   logic [1:0]     mdt_ctl;
   logic [15:0]    mdt_svc;
   rsc_cyc_t       mdt_cyc;
   logic [2:0]     mdt_len;

   modport master (
      output mst, phase, mdt_valid, mdt_ctl, mdt_svc, mdt_cyc, mdt_len,
      input  at_valid, at_ack, at_stat, at_svc, at_cyc, at_len
   );
   modport drive (
      input  mst, phase, mdt_valid, mdt_ctl, mdt_svc, mdt_cyc, mdt_len,
      output at_valid, at_ack, at_stat, at_svc, at_cyc, at_len
   );
endinterface

/* File: rtl/rsc_req_fifo.sv */
`timescale 1ns/1ps
module rsc_req_fifo (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   // Fill side
   input  wire logic              in_valid_i,
   input  wire rsc_pkg::rsc_req_t in_data_i,
   output logic                   in_ready_o,
   // Drain side
   output logic                   out_valid_o,
   input  wire logic              out_ready_i,
   output rsc_pkg::rsc_req_t      out_data_o
);
   import rsc_pkg::*;

   rsc_req_t       mem_q [QDEPTH];
   logic [QAW-1:0] wr_q;
   logic [QAW-1:0] rd_q;
   logic [QAW:0]   cnt_q;
   logic [QAW:0]   cnt_d;
   logic           push;
   logic           pop;

   assign push       = in_valid_i && in_ready_o;
   assign pop        = out_ready_i && out_valid_o;
   assign cnt_d      = cnt_q + {4'h0, push} - {4'h0, pop};
   assign out_data_o = mem_q[rd_q];

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q        <= '0;
         rd_q        <= '0;
         cnt_q       <= '0;
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 4'h1;
         end
         if (pop) begin
            rd_q <= rd_q + 4'h1;
         end
         cnt_q       <= cnt_d;
         in_ready_o  <= cnt_d != QFULL;
         out_valid_o <= cnt_d != 5'h00;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end
endmodule

/* File: rtl/rsc_master.sv */
`timescale 1ns/1ps
module rsc_master (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   // Ring link
   rsc_link_if.master             lnk,
   // Startup control
   input  wire logic              hold_i,
   input  wire logic [2:0]        cyc_words_i,
   output logic [2:0]             phase_o,
   output logic [2:0]             phase_done_o,
   // Cyclic data
   input  wire rsc_pkg::rsc_cyc_t cyc_cmd_i,
   output rsc_pkg::rsc_cyc_t      cyc_fb_o,
   output logic [15:0]            drv_stat_o,
   // Application requests
   input  wire logic              app_valid_i,
   input  wire rsc_pkg::rsc_req_t app_req_i,
   output logic                   app_ready_o,
   output logic                   app_reject_o,
   // Diagnostic tool requests
   input  wire logic              diag_valid_i,
   input  wire rsc_pkg::rsc_req_t diag_req_i,
   output logic                   diag_ready_o,
   // Results
   output logic                   res_valid_o,
   output logic                   res_diag_o,
   output logic [15:0]            res_data_o
);
   import rsc_pkg::*;

   rsc_upd_t    upd_q;
   rsc_upd_t    upd_d;
   rsc_svc_t    svc_q;
   rsc_svc_t    svc_d;
   logic [11:0] tmr_q;
   logic [2:0]  ncomp_q;
   logic [2:0]  phase_q;
   logic [2:0]  cyc_len_q;
   logic        mst_q;
   logic        mdt_q;
   logic [1:0]  mdt_ctl_q;
   logic [15:0] mdt_svc_q;
   rsc_cyc_t    mdt_cyc_q;
   logic [2:0]  mdt_len_q;
   rsc_req_t    cur_q;
   logic        cur_diag_q;
   rsc_req_t    diag_q;
   logic        dslot_q;
   logic        dslot_d;
   logic        tick;
   logic        at_seen;
   logic        mdt_go;
   logic        held;
   logic [2:0]  ph_w;
   logic        adv;
   logic        svc_ok;
   logic        q_valid;
   rsc_req_t    q_data;
   logic        take_app;
   logic        take_diag;
   logic        take;
   logic        finish;
   rsc_req_t    new_req;
   logic [1:0]  ctl_w;
   logic [15:0] svc_w;
   rsc_cyc_t    cyc_w;
   logic [2:0]  len_w;

   // ==========================================================
   // Application queue
   rsc_req_fifo u_queue (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_valid_i  (app_valid_i),
      .in_data_i   (app_req_i),
      .in_ready_o  (app_ready_o),
      .out_valid_o (q_valid),
      .out_ready_i (take_app),
      .out_data_o  (q_data)
   );

   // ==========================================================
   // Update sequencing: sync, wait drive telegram, then data
   assign tick    = tmr_q == TMR_LAST;
   assign at_seen = (upd_q == U_WAIT) && lnk.at_valid;
   assign mdt_go  = (upd_q == U_WAIT) && (lnk.at_valid || tick);

   always_comb begin
      upd_d = upd_q;
      case (upd_q)
         U_IDLE: begin
            if (tick) begin
               upd_d = U_MST;
            end
         end
         U_MST:  upd_d = U_WAIT;
         U_WAIT: begin
            if (mdt_go) begin
               upd_d = U_MDT;
            end
         end
         U_MDT:  upd_d = U_IDLE;
         default: upd_d = U_IDLE;
      endcase
   end

   // ==========================================================
   // Phase stepping
   assign held   = hold_i && (ncomp_q == DONE_SVC);
   assign ph_w   = held ? PH_CYC : ((ncomp_q == DONE_ALL) ? PH_LAST : ncomp_q);
   assign adv    = at_seen && lnk.at_ack && (phase_q == ncomp_q);
   assign svc_ok = ncomp_q >= DONE_SVC;
   assign len_w  = (cyc_words_i > CYC_MAX) ? CYC_MAX : cyc_words_i;

   // ==========================================================
   // Service channel
   assign take_app  = mdt_go && (svc_q == SV_IDLE) && svc_ok && q_valid;
   assign take_diag = mdt_go && (svc_q == SV_IDLE) && svc_ok && !q_valid && dslot_q;
   assign take      = take_app || take_diag;
   assign finish    = mdt_go && (svc_q == SV_HDR);
   assign new_req   = q_valid ? q_data : diag_q;
   assign ctl_w     = take ? SC_HDR : (finish ? SC_DATA : SC_NONE);
   assign svc_w     = take ? {new_req.wr, new_req.element_selector, new_req.idn}
                           : (finish ? cur_q.data : 16'h0000);
   assign dslot_d   = (dslot_q && !take_diag) || (diag_valid_i && diag_ready_o);

   always_comb begin
      svc_d = svc_q;
      case (svc_q)
         SV_IDLE: begin
            if (take) begin
               svc_d = SV_HDR;
            end
         end
         SV_HDR: begin
            if (finish) begin
               svc_d = SV_IDLE;
            end
         end
         default: svc_d = SV_IDLE;
      endcase
   end

   // ==========================================================
   // Cyclic words, zero until phase 4 completes
   for (genvar i = 0; i < NCYC; i++) begin : g_cyc
      assign cyc_w[i] = ((ncomp_q == DONE_ALL) && (i < cyc_len_q)) ? cyc_cmd_i[i] : 16'h0000;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         upd_q   <= U_IDLE;
         svc_q   <= SV_IDLE;
         tmr_q   <= '0;
         ncomp_q <= '0;
         phase_q <= '0;
         mst_q   <= 1'b0;
      end else begin
         upd_q   <= upd_d;
         svc_q   <= svc_d;
         tmr_q   <= tick ? 12'h000 : tmr_q + 12'h001;
         mst_q   <= (upd_q == U_IDLE) && tick;
         if ((upd_q == U_IDLE) && tick) begin
            phase_q <= ph_w;
         end
         if (adv) begin
            ncomp_q <= ncomp_q + 3'h1;
         end
      end
   end

   // Init writes carry only the cyclic length, never a procedure
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cyc_len_q <= '0;
      end else if (adv && (ncomp_q == PH_CYC)) begin
         cyc_len_q <= len_w;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mdt_q     <= 1'b0;
         mdt_ctl_q <= SC_NONE;
         mdt_svc_q <= '0;
         mdt_cyc_q <= '0;
         mdt_len_q <= '0;
      end else begin
         mdt_q <= mdt_go;
         if (mdt_go) begin
            mdt_ctl_q <= ctl_w;
            mdt_svc_q <= svc_w;
            mdt_cyc_q <= cyc_w;
            mdt_len_q <= cyc_len_q;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cur_q        <= '0;
         cur_diag_q   <= 1'b0;
         diag_q       <= '0;
         dslot_q      <= 1'b0;
         diag_ready_o <= 1'b1;
         app_reject_o <= 1'b0;
         res_valid_o  <= 1'b0;
         res_diag_o   <= 1'b0;
         res_data_o   <= '0;
      end else begin
         dslot_q      <= dslot_d;
         diag_ready_o <= !dslot_d;
         app_reject_o <= app_valid_i && !app_ready_o;
         if (diag_valid_i && diag_ready_o) begin
            diag_q <= diag_req_i;
         end
         if (take) begin
            cur_q      <= new_req;
            cur_diag_q <= take_diag;
         end
         res_valid_o <= finish;
         if (finish) begin
            res_diag_o <= cur_diag_q;
            res_data_o <= cur_q.wr ? cur_q.data : lnk.at_svc;
         end
      end
   end

   // Drive status keeps the change bit for polling software
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         drv_stat_o <= '0;
         cyc_fb_o   <= '0;
      end else if (at_seen) begin
         drv_stat_o <= lnk.at_stat;
         if (ncomp_q == DONE_ALL) begin
            cyc_fb_o <= lnk.at_cyc;
         end
      end
   end

   assign lnk.mst       = mst_q;
   assign lnk.phase     = phase_q;
   assign lnk.mdt_valid = mdt_q;
   assign lnk.mdt_ctl   = mdt_ctl_q;
   assign lnk.mdt_svc   = mdt_svc_q;
   assign lnk.mdt_cyc   = mdt_cyc_q;
   assign lnk.mdt_len   = mdt_len_q;
   assign phase_o       = phase_q;
   assign phase_done_o  = ncomp_q;
endmodule

/* File: rtl/rsc_drive.sv */
`timescale 1ns/1ps
module rsc_drive (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   // Ring link
   rsc_link_if.drive              lnk,
   // Drive side
   input  wire rsc_pkg::rsc_cyc_t cyc_fb_i,
   input  wire logic              proc_fail_i,
   output rsc_pkg::rsc_cyc_t      cyc_cmd_o,
   output logic [2:0]             phase_o,
   output logic [15:0]            proc_stat_o,
   output logic                   order_err_o
);
   import rsc_pkg::*;

   logic [15:0] par_q [NPAR];
   logic [15:0] proc_q;
   logic [15:0] proc_d;
   logic        chg_q;
   logic        chg_d;
   logic [3:0]  ptmr_q;
   logic [2:0]  phase_q;
   logic [15:0] hdr_q;
   logic [2:0]  len_q;
   logic        at_q;
   logic        ack_q;
   logic [15:0] stat_q;
   logic [15:0] atsvc_q;
   rsc_cyc_t    atcyc_q;
   rsc_cyc_t    fb_w;
   logic        ph_ok;
   logic        is_proc;
   logic        opd;
   logic [15:0] rd_w;
   logic        dat_go;
   logic        wr_go;
   logic        proc_wr;
   logic        rd_proc;
   logic        cyc_go;
   logic        pdone;
   logic [NPAR-1:0] we_svc;
   logic [NPAR-1:0] we_cyc;

   // ==========================================================
   // Decode
   assign ph_ok   = (lnk.phase == phase_q) || (lnk.phase == phase_q + 3'h1);
   assign is_proc = hdr_q[11:0] == PROC_IDN;
   assign opd     = hdr_q[14:12] == EL_OPDATA;
   assign rd_w    = opd ? (is_proc ? proc_q : par_q[hdr_q[2:0]]) : {1'b0, hdr_q[14:0]};
   assign dat_go  = lnk.mdt_valid && (lnk.mdt_ctl == SC_DATA);
   assign wr_go   = dat_go && hdr_q[15];
   assign proc_wr = wr_go && is_proc && opd;
   assign rd_proc = dat_go && !hdr_q[15] && is_proc && opd;
   assign cyc_go  = lnk.mdt_valid && (phase_q == PH_LAST);
   assign pdone   = lnk.mst && proc_q[PB_EXEC] && (ptmr_q == PTMR_ONE);

   // ==========================================================
   // Procedure handshake
   always_comb begin
      proc_d = proc_q;
      if (proc_wr && !lnk.mdt_svc[PB_SET]) begin
         proc_d = PROC_IDLE;
      end else if (proc_wr && (lnk.mdt_svc == PROC_START) && (proc_q == PROC_IDLE)) begin
         proc_d = PROC_RUN;
      end else if (pdone) begin
         proc_d = proc_fail_i ? PROC_FAIL : PROC_OK;
      end
   end
   assign chg_d = (proc_d != proc_q) || (chg_q && !rd_proc);

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         proc_q <= PROC_IDLE;
         chg_q  <= 1'b0;
         ptmr_q <= '0;
      end else begin
         proc_q <= proc_d;
         chg_q  <= chg_d;
         if ((proc_d == PROC_RUN) && (proc_q == PROC_IDLE)) begin
            ptmr_q <= PTMR_INIT;
         end else if (lnk.mst && proc_q[PB_EXEC] && (ptmr_q != 4'h0)) begin
            ptmr_q <= ptmr_q - 4'h1;
         end
      end
   end

   // ==========================================================
   // Parameters, operation data written by service or cyclic
   for (genvar i = 0; i < NPAR; i++) begin : g_par
      assign we_svc[i] = wr_go && opd && !is_proc && (hdr_q[2:0] == 3'(i));
      assign we_cyc[i] = (i < NCYC) && cyc_go && (i < lnk.mdt_len);
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            par_q[i] <= PAR_RST;
         end else if (we_svc[i]) begin
            par_q[i] <= lnk.mdt_svc;
         end else if (we_cyc[i]) begin
            par_q[i] <= lnk.mdt_cyc[i % NCYC];
         end
      end
      if (i < NCYC) begin : g_io
         assign cyc_cmd_o[i] = par_q[i];
         assign fb_w[i]      = ((phase_q == PH_LAST) && (i < len_q)) ? cyc_fb_i[i] : 16'h0000;
      end
   end

   // ==========================================================
   // Answers, only after a sync telegram
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_q     <= '0;
         hdr_q       <= '0;
         len_q       <= '0;
         at_q        <= 1'b0;
         ack_q       <= 1'b0;
         stat_q      <= '0;
         atsvc_q     <= '0;
         atcyc_q     <= '0;
         order_err_o <= 1'b0;
      end else begin
         at_q <= lnk.mst;
         if (lnk.mst) begin
            ack_q       <= ph_ok;
            order_err_o <= order_err_o || !ph_ok;
            if (ph_ok) begin
               phase_q <= lnk.phase;
            end
            stat_q  <= {10'h000, chg_d, 2'b00, phase_q};
            atsvc_q <= rd_w;
            atcyc_q <= fb_w;
         end
         if (lnk.mdt_valid) begin
            len_q <= lnk.mdt_len;
            if (lnk.mdt_ctl == SC_HDR) begin
               hdr_q <= lnk.mdt_svc;
            end
         end
      end
   end

   assign lnk.at_valid = at_q;
   assign lnk.at_ack   = ack_q;
   assign lnk.at_stat  = stat_q;
   assign lnk.at_svc   = atsvc_q;
   assign lnk.at_cyc   = atcyc_q;
   assign lnk.at_len   = len_q;
   assign phase_o      = phase_q;
   assign proc_stat_o  = proc_q;
endmodule

/* File: verif/rsc_link_properties.sv */
`timescale 1ns/1ps
module rsc_link_properties (
   // Clock and reset
   input wire logic              mclk_i,
   input wire logic              rst_i,
   // Link signals
   input wire logic              mst,
   input wire logic [2:0]        phase,
   input wire logic              at_valid,
   input wire rsc_pkg::rsc_cyc_t at_cyc,
   input wire logic [2:0]        at_len,
   input wire logic              mdt_valid,
   input wire logic [1:0]        mdt_ctl,
   input wire rsc_pkg::rsc_cyc_t mdt_cyc,
   input wire logic [2:0]        mdt_len
);
   import rsc_pkg::*;
   // ==========================================================
   // Helper state: cycles since sync and since data telegram
   logic [12:0] gap_q;
   logic [12:0] wait_q;
   logic        seen_q;
   logic        pend_q;
   logic [2:0]  ph_q;
   logic [2:0]  len_q;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_q  <= 13'h0;
         wait_q <= 13'h0;
         seen_q <= 1'b0;
         pend_q <= 1'b0;
         ph_q   <= 3'h0;
         len_q  <= 3'h0;
      end else begin
         gap_q  <= mst ? 13'h1 : gap_q + 13'h1;
         wait_q <= mdt_valid ? 13'h0 : wait_q + 13'h1;
         seen_q <= seen_q | mst;
         pend_q <= mdt_valid ? (mdt_ctl == SC_HDR) : pend_q;
         ph_q   <= mst ? phase : ph_q;
         len_q  <= mdt_valid ? mdt_len : len_q;
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_update;
      mst ##1 at_valid ##1 mdt_valid;
   endsequence

   update_order_a: assert property (mst |-> s_update)
      else $error("telegram order broken");
   at_only_answer_a: assert property (at_valid |-> $past(mst))
      else $error("drive telegram without sync");
   mst_period_a: assert property ((mst && seen_q) |-> gap_q == 13'hfa0)
      else $error("update period wrong");
   phase_order_a: assert property ((mst && seen_q) |-> (phase == ph_q || phase == ph_q + 3'h1))
      else $error("phase skipped or reversed");
   cyc_hidden_a: assert property ((mdt_valid && phase != PH_LAST) |-> mdt_cyc == '0)
      else $error("cyclic data before phase 4");
   len_fixed_a: assert property ((mdt_valid && phase > PH_CYC) |-> (mdt_len == len_q && mdt_len <= CYC_MAX))
      else $error("cyclic length changed");
   at_cyc_clear_a: assert property ((at_valid && at_len < 3'h4) |-> at_cyc[3] == 16'h0)
      else $error("cyclic word beyond length");
   svc_gate_a: assert property ((mdt_valid && mdt_ctl != SC_NONE) |-> phase >= PH_CYC)
      else $error("service word too early");
   hdr_data_a: assert property ((mdt_valid && pend_q) |-> mdt_ctl == SC_DATA)
      else $error("header not followed by data");
   hdr_bound_a: assert property (pend_q |-> wait_q <= 13'hfa0)
      else $error("data word late");
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
   import rsc_pkg::*;
   // ==========================================================
   // Signals
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        hold_i = 1'b1;
   logic        app_valid_i = 1'b0;
   logic        diag_valid_i = 1'b0;
   logic        proc_fail_i = 1'b0;
   logic [2:0]  cyc_words_i = 3'h1;
   rsc_cyc_t    cyc_cmd_i = '0;
   rsc_cyc_t    cyc_fb_i = '0;
   rsc_req_t    app_req_i = '0;
   rsc_req_t    diag_req_i = '0;
   rsc_cyc_t    cyc_fb_o, cyc_cmd_o;
   logic        app_ready_o, app_reject_o, diag_ready_o, res_valid_o, res_diag_o, order_err_o;
   logic [2:0]  phase_o, phase_done_o, drv_phase;
   logic [15:0] res_data_o, proc_stat_o, drv_stat_o, d;
   logic [16:0] exp_q[$];
   int          errors = 0;
   int          check_count = 0;
   int          cycles = 0;

   always #12.5 mclk_i = ~mclk_i;

   // ==========================================================
   // Both ends and the checker
   rsc_link_if lnk();
   rsc_master u_rsc_master (.mclk_i, .rst_i, .lnk(lnk.master), .hold_i, .cyc_words_i, .phase_o,
      .phase_done_o, .cyc_cmd_i, .cyc_fb_o, .drv_stat_o, .app_valid_i, .app_req_i, .app_ready_o,
      .app_reject_o, .diag_valid_i, .diag_req_i, .diag_ready_o, .res_valid_o, .res_diag_o, .res_data_o);
   rsc_drive u_rsc_drive (.mclk_i, .rst_i, .lnk(lnk.drive), .cyc_fb_i, .proc_fail_i, .cyc_cmd_o,
      .phase_o(drv_phase), .proc_stat_o, .order_err_o);
   rsc_link_properties u_rsc_link_properties (.mclk_i, .rst_i, .mst(lnk.mst), .phase(lnk.phase),
      .at_valid(lnk.at_valid), .at_cyc(lnk.at_cyc), .at_len(lnk.at_len), .mdt_valid(lnk.mdt_valid),
      .mdt_ctl(lnk.mdt_ctl), .mdt_cyc(lnk.mdt_cyc), .mdt_len(lnk.mdt_len));

   // ==========================================================
   // Checking and closing
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 110000) begin
         errors++;
         report_and_stop();
      end
   end

   // Results are sampled mid-cycle, away from the edge that launches them
   always @(negedge mclk_i) begin
      if (res_valid_o === 1'b1) begin
         if (exp_q.size() == 0) check({res_diag_o, res_data_o}, 17'h1ffff);
         else check({res_diag_o, res_data_o}, exp_q.pop_front());
      end
   end

   // ==========================================================
   // Stimulus
   task automatic push(input logic diag, input logic wr, input rsc_element_selector_t el, input logic [11:0] idn,
                       input logic [15:0] data, input logic [15:0] res);
      @(negedge mclk_i);
      if (diag) diag_req_i = {wr, el, idn, data};
      else app_req_i = {wr, el, idn, data};
      diag_valid_i = diag;
      app_valid_i = !diag;
      while ((diag ? diag_ready_o : app_ready_o) !== 1'b1) @(negedge mclk_i);
      @(posedge mclk_i);
      exp_q.push_back({diag, res});
      @(negedge mclk_i);
      app_valid_i = 1'b0;
      diag_valid_i = 1'b0;
   endtask

   task automatic wait_done(input logic [2:0] v);
      while (phase_done_o !== v) @(negedge mclk_i);
   endtask

   task automatic drain;
      while (exp_q.size() > 0) @(negedge mclk_i);
      @(negedge mclk_i);
   endtask

   initial begin
      void'($urandom(32'h394e));
      cyc_words_i = 3'h1 + 3'($urandom_range(3));
      cyc_cmd_i = {$urandom, $urandom};
      cyc_fb_i = {$urandom, $urandom};
      d = 16'($urandom);
      repeat (20) @(negedge mclk_i);
      rst_i = 1'b0;
      @(negedge mclk_i);
      app_valid_i = 1'b1;
      repeat (16) begin
         app_req_i = {1'b0, EL_OPDATA, 12'h5, 16'($urandom)};
         @(negedge mclk_i);
      end
      check(app_ready_o, 1'b0);
      @(negedge mclk_i);
      check(app_reject_o, 1'b1);
      app_valid_i = 1'b0;
      rst_i = 1'b1;
      @(negedge mclk_i);
      rst_i = 1'b0;
      wait_done(DONE_SVC);
      check(proc_stat_o, PROC_IDLE);
      push(1'b0, 1'b1, EL_OPDATA, PROC_IDN, PROC_START, PROC_START);
      push(1'b0, 1'b1, EL_OPDATA, 12'h5, d, d);
      push(1'b0, 1'b0, EL_OPDATA, 12'h5, 16'h0, d);
      push(1'b0, 1'b0, EL_OPDATA, PROC_IDN, 16'h0, PROC_OK);
      push(1'b0, 1'b1, EL_OPDATA, PROC_IDN, PROC_IDLE, PROC_IDLE);
      drain();
      check(phase_done_o, DONE_SVC);
      check(proc_stat_o[3:0], 4'h0);
      check(phase_o, PH_CYC);
      hold_i = 1'b0;
      proc_fail_i = 1'b1;
      push(1'b0, 1'b1, EL_OPDATA, PROC_IDN, PROC_START, PROC_START);
      push(1'b0, 1'b0, EL_OPDATA, PROC_IDN, 16'h0, PROC_RUN);
      push(1'b0, 1'b0, EL_OPDATA, 12'h5, 16'h0, d);
      push(1'b0, 1'b0, EL_OPDATA, PROC_IDN, 16'h0, PROC_FAIL);
      push(1'b0, 1'b1, EL_OPDATA, PROC_IDN, PROC_IDLE, PROC_IDLE);
      push(1'b1, 1'b0, EL_UNITS, PROC_IDN, 16'h0, {1'b0, EL_UNITS, PROC_IDN});
      drain();
      wait_done(DONE_ALL);
      check(drv_stat_o, {10'h000, 1'b1, 2'b00, PH_LAST});
      for (int i = 0; i < NCYC; i++) begin
         check(cyc_fb_o[i], (i < cyc_words_i) ? cyc_fb_i[i] : 16'h0);
         if (i < cyc_words_i) check(cyc_cmd_o[i], cyc_cmd_i[i]);
      end
      check(drv_phase, PH_LAST);
      check(order_err_o, 1'b0);
      report_and_stop();
   end
endmodule
